// ---- core/mmw_slave.sv ----
// slave end: small word memory with wait states and byte lanes
// Operation
// - read data output and write data plus strobe
// - read strobe marks a read transfer
// - write strobe marks a write transfer
// - address is a word offset from zero
// - read data width power of two, 8..1024
// - read and write data share one width
// - one lane enable bit per data byte
// - writes update only enabled byte lanes
// - side-effect-free reads return the full word
// - fabric sends only aligned power-of-two lane groups
// - single lane bit n selects byte n
// - fabric marks first cycle of every transfer
// - stall while request cannot yet complete
// - fabric holds controls steady while stalled
// - stall allowed while idle
// - transfer may start during stall
// - active-low variants allowed, same meaning
// - one signal of each type per port
// - inputs sampled on clock edges only
// - reset released synchronously to clock
`timescale 1ns/1ns
module mmw_slave #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32,
  parameter int WAIT_C = mmw_pkg::WAIT_CYC_DEF
) (
  input  wire logic i_clock,       // port clock
  input  wire logic i_srst,        // synchronous reset, high
  mmw_if.slave      bus,           // link to the interconnect
  output logic      o_busy         // high while a transfer is pending
);
  localparam int LANES   = DATA_W / mmw_pkg::BYTE_W;
  localparam int WORDS   = 1 << ADDR_W;
  localparam int CNT_W   = $clog2(WAIT_C + 2);
  localparam bit NO_WAIT = (WAIT_C == 0);

  // refuse parameter values the logic cannot serve; the store is a plain
  // array, so its address width is capped well below the port maximum
  initial begin
    if (ADDR_W < mmw_pkg::ADDR_W_MIN || ADDR_W > mmw_pkg::ADDR_W_MAX) begin
      $error("address width out of range");
    end
    if (ADDR_W > mmw_pkg::ADDR_W_MEM) begin
      $error("address width too wide for the local store");
    end
    if (DATA_W < mmw_pkg::DATA_W_MIN || DATA_W > mmw_pkg::DATA_W_MAX) begin
      $error("data width out of range");
    end
    if ((DATA_W & (DATA_W - 1)) != 0) begin
      $error("data width must be a power of two");
    end
    if ((DATA_W % mmw_pkg::BYTE_W) != 0) begin
      $error("data width must hold whole bytes");
    end
    if (WAIT_C < 0) begin
      $error("wait count negative");
    end
  end

  // sequencer states: waiting for a request, counting wait cycles,
  // and the single cycle in which stall is low and the transfer completes
  typedef enum logic [1:0] {
    MMW_IDLE,
    MMW_WAIT,
    MMW_DONE
  } mmw_state_t;

  mmw_state_t        state_ff;    // sequencer state
  mmw_state_t        nxt_state;   // next sequencer state
  logic [CNT_W-1:0]  cnt_ff;      // wait cycles still to run
  logic [CNT_W-1:0]  nxt_cnt;     // next wait count
  logic [DATA_W-1:0] rdata_ff;    // read word shown to the fabric
  logic [DATA_W-1:0] nxt_rdata;   // next read word
  logic              busy_ff;     // a transfer is pending
  logic              nxt_busy;    // next pending flag
  logic              req;         // read or write strobe present
  logic              take;        // request seen while idle
  logic              last_wait;   // final counted wait cycle
  logic              enter_done;  // this edge opens the done cycle
  logic              wr_done;     // a write completes at this edge
  logic [DATA_W-1:0] rd_word;     // word at the current address, all lanes

  // either strobe is a request; the fabric never sends both
  assign req        = bus.rd | bus.wr;
  // taken only from idle; later edges see the fabric's held copy
  assign take       = (state_ff == MMW_IDLE) & req;
  // the count runs down to one, then the done cycle follows
  assign last_wait  = (cnt_ff <= CNT_W'(1));
  // the edge that moves the sequencer into its done cycle
  assign enter_done = (nxt_state == MMW_DONE) & (state_ff != MMW_DONE);
  // the store changes only at the completing edge of a write
  assign wr_done    = (state_ff == MMW_DONE) & bus.wr;

  // sequencer; stall stays high while idle so a new request always
  // meets the stall first, which keeps the paths uniform
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MMW_IDLE: begin
        if (take && NO_WAIT) begin
          nxt_state = MMW_DONE;                    // no wait cycles configured
        end else if (take) begin
          nxt_state = MMW_WAIT;
        end
      end
      MMW_WAIT: begin
        if (last_wait) begin
          nxt_state = MMW_DONE;
        end
      end
      MMW_DONE: begin
        nxt_state = MMW_IDLE;                      // transfer completes this edge
      end
      default: begin
        nxt_state = MMW_IDLE;
      end
    endcase
  end

  // sequencer register; inputs are sampled on clock edges only
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_ff <= MMW_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // wait counter: loaded on the take, run down while waiting
  always_comb begin
    nxt_cnt = cnt_ff;
    if (take) begin
      nxt_cnt = CNT_W'(WAIT_C);
    end else if (state_ff == MMW_WAIT) begin
      nxt_cnt = cnt_ff - CNT_W'(1);
    end
  end

  // counter register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // read word fetched as the done cycle opens, so it stands while stall
  // is low; held until the done cycle of the next read opens
  always_comb begin
    nxt_rdata = rdata_ff;
    if (enter_done && bus.rd) begin
      nxt_rdata = rd_word;                         // address steady under stall
    end
  end

  // read word register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // pending flag: set on the take, cleared as the done cycle closes;
  // a flop, so the output never glitches while the state decodes
  always_comb begin
    nxt_busy = busy_ff;
    if (take) begin
      nxt_busy = 1'b1;
    end else if (state_ff == MMW_DONE) begin
      nxt_busy = 1'b0;
    end
  end

  // pending register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
    end
  end

  // stall until the done cycle, idle included; active-high forms only,
  // one signal of each kind on the port
  assign bus.stall = (state_ff != MMW_DONE);
  // full word returned; reads have no side effect so lanes are ignored
  assign bus.rdata = rdata_ff;
  assign o_busy    = busy_ff;

  // byte-lane store: each lane owns its array, so no two processes write
  // one variable; a lane changes only at the completing edge of a write,
  // and only when its enable bit is set
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [mmw_pkg::BYTE_W-1:0] lane_mem_ff [WORDS]; // lane byte per word, addr 0 first
      logic                       lane_we;             // this lane is written now
      logic [mmw_pkg::BYTE_W-1:0] lane_wbyte;          // this lane's write byte

      // lane bit g selects byte g of the write word
      assign lane_we    = wr_done & bus.lane_en[g];
      assign lane_wbyte = bus.wdata[g*mmw_pkg::BYTE_W +: mmw_pkg::BYTE_W];

      // no reset on the store: words read before written come back unknown
      always_ff @(posedge i_clock) begin
        if (lane_we) begin
          lane_mem_ff[bus.addr] <= lane_wbyte;         // disabled lanes keep their byte
        end
      end

      // read side takes every lane; reads have no side effects
      assign rd_word[g*mmw_pkg::BYTE_W +: mmw_pkg::BYTE_W] = lane_mem_ff[bus.addr];
    end
  endgenerate
endmodule

// ---- core/mmw_pkg.sv ----
// shared constants for the memory-mapped wait-state port
package mmw_pkg;
  localparam int ADDR_W_MIN   = 1;
  localparam int ADDR_W_MAX   = 32;
  localparam int DATA_W_MIN   = 8;
  localparam int DATA_W_MAX   = 1024;
  localparam int BYTE_W       = 8;
  localparam int WAIT_CYC_DEF = 2;   // counted wait cycles per transfer, default
  localparam int MEM_WORDS    = 16;  // words held by the device end
  localparam int ADDR_W_MEM   = 10;  // widest address the local store serves
endpackage

// ---- core/mmw_if.sv ----
// interface joining the interconnect end and the slave end
`timescale 1ns/1ns
interface mmw_if #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32
) (
  input wire logic i_clock
);
  logic                  rd;        // read strobe
  logic                  wr;        // write strobe
  logic [ADDR_W-1:0]     addr;      // word address
  logic [DATA_W-1:0]     wdata;     // write data
  logic [DATA_W-1:0]     rdata;     // read data
  logic [DATA_W/8-1:0]   lane_en;   // byte-lane enables
  logic                  first;     // first cycle of a transfer
  logic                  stall;     // stall request from slave

  modport slave (input rd, wr, addr, wdata, lane_en, first, output rdata, stall);
  modport fabric (output rd, wr, addr, wdata, lane_en, first, input rdata, stall);
endinterface

// ---- core/mmw_fabric.sv ----
// interconnect end: drives one read or write per user command
`timescale 1ns/1ns
module mmw_fabric #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32
) (
  input  wire logic                i_clock,    // port clock
  input  wire logic                i_srst,     // synchronous reset, high
  mmw_if.fabric                    bus,        // link to the slave
  input  wire logic                i_go,       // start pulse, taken when ready and the lane group is legal
  input  wire logic                i_write,    // 1 write, 0 read
  input  wire logic [ADDR_W-1:0]   i_addr,     // word address
  input  wire logic [DATA_W-1:0]   i_wdata,    // write data
  input  wire logic [DATA_W/8-1:0] i_lanes,    // lane enables
  output logic                     o_ready,    // idle, may accept i_go
  output logic                     o_done,     // one-cycle completion pulse
  output logic [DATA_W-1:0]        o_rdata     // read result, held
);
  localparam int LANES = DATA_W / mmw_pkg::BYTE_W;

  initial begin
    if (DATA_W < mmw_pkg::DATA_W_MIN || DATA_W > mmw_pkg::DATA_W_MAX || (DATA_W & (DATA_W - 1)) != 0)
      $error("data width must be a power of two 8..1024");
  end

  // a lane pattern is legal if one aligned power-of-two group
  function automatic logic lanes_ok(input logic [LANES-1:0] le);
    logic ok;
    ok = 1'b0;
    for (int s = 1; s <= LANES; s = s * 2)
      for (int b = 0; b < LANES; b = b + s)
        if (le == (({LANES{1'b1}} >> (LANES - s)) << b))
          ok = 1'b1;
    return ok;
  endfunction

  logic              act_ff,   nxt_act;
  logic              first_ff, nxt_first;
  logic              wr_ff,    nxt_wr;
  logic [ADDR_W-1:0] addr_ff,  nxt_addr;
  logic [DATA_W-1:0] wd_ff,    nxt_wd;
  logic [LANES-1:0]  le_ff,    nxt_le;
  logic [DATA_W-1:0] rd_ff,    nxt_rd;
  logic              done_ff,  nxt_done;

  // request holder; controls frozen until stall drops
  always_comb begin
    nxt_act   = act_ff;
    nxt_first = 1'b0;                      // marker only for one cycle
    nxt_wr    = wr_ff;
    nxt_addr  = addr_ff;
    nxt_wd    = wd_ff;
    nxt_le    = le_ff;
    nxt_rd    = rd_ff;
    nxt_done  = 1'b0;
    if (!act_ff && i_go && lanes_ok(i_lanes)) begin
      nxt_act   = 1'b1;
      nxt_first = 1'b1;
      nxt_wr    = i_write;
      nxt_addr  = i_addr;
      nxt_wd    = i_wdata;
      nxt_le    = i_lanes;
    end else if (act_ff && !bus.stall) begin // completion edge
      nxt_act  = 1'b0;
      nxt_done = 1'b1;
      if (!wr_ff)
        nxt_rd = bus.rdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      act_ff   <= 1'b0;
      first_ff <= 1'b0;
      wr_ff    <= 1'b0;
      addr_ff  <= '0;
      wd_ff    <= '0;
      le_ff    <= '0;
      rd_ff    <= '0;
      done_ff  <= 1'b0;
    end else begin
      act_ff   <= nxt_act;
      first_ff <= nxt_first;
      wr_ff    <= nxt_wr;
      addr_ff  <= nxt_addr;
      wd_ff    <= nxt_wd;
      le_ff    <= nxt_le;
      rd_ff    <= nxt_rd;
      done_ff  <= nxt_done;
    end
  end

  // strobes only while a transfer is held
  assign bus.rd      = act_ff & ~wr_ff;
  assign bus.wr      = act_ff & wr_ff;
  assign bus.addr    = addr_ff;
  assign bus.wdata   = wd_ff;
  assign bus.lane_en = le_ff;
  assign bus.first   = first_ff;
  assign o_ready     = ~act_ff;
  assign o_done      = done_ff;
  assign o_rdata     = rd_ff;
endmodule

// ---- test/mmw_assertions.sv ----
// link assertions between interconnect and slave
`timescale 1ns/1ns
module mmw_checker #(
  parameter int WAIT_C = 2,
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32
) (
  input wire logic                i_clock,   // port clock
  input wire logic                i_srst,    // synchronous reset, high
  input wire logic                i_rd,      // read strobe
  input wire logic                i_wr,      // write strobe
  input wire logic [ADDR_W-1:0]   i_addr,    // word address
  input wire logic [DATA_W-1:0]   i_wdata,   // write data
  input wire logic [DATA_W-1:0]   i_rdata,   // read data
  input wire logic [DATA_W/8-1:0] i_lane_en, // byte-lane enables
  input wire logic                i_first,   // first-cycle marker
  input wire logic                i_stall    // stall request
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // wait cycles under stall, then one low cycle
  sequence s_wait; i_stall throughout (##WAIT_C 1'b1); endsequence
  sequence s_done; !i_stall ##1 i_stall; endsequence
  a_stall_timing: assert property (i_first |-> s_wait ##1 s_done)
    else $error("stall timing");
  a_first_rise: assert property ($rose(i_rd | i_wr) |-> i_first)
    else $error("no first marker");
  a_first_once: assert property (i_first |-> (i_rd | i_wr) ##1 !i_first)
    else $error("first marker too long");
  // controls may not move under a stall
  a_hold_ctrl: assert property ((i_rd | i_wr) && i_stall |=> $stable({i_rd, i_wr, i_addr, i_wdata, i_lane_en}))
    else $error("control moved while stalled");
  a_drop_strobe: assert property ((i_rd | i_wr) && !i_stall |=> !(i_rd | i_wr))
    else $error("strobe kept");
  a_idle_stall: assert property (!(i_rd | i_wr) |-> i_stall)
    else $error("idle without stall");
  a_one_kind: assert property (!(i_rd && i_wr))
    else $error("read and write together");
  a_lanes_legal: assert property ((i_rd | i_wr) |-> i_lane_en inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
    else $error("illegal lane group");
  // read data may only change when a read completes
  a_rdata_hold: assert property (!$stable(i_rdata) |-> i_rd && !i_stall)
    else $error("read data moved outside a read");
endmodule

// ---- test/mm_slave_port_waitstate_bench.sv ----
// bench joining interconnect and slave ends
`timescale 1ns/1ns
module mm_slave_port_waitstate_bench;
  logic        i_clock = 1'b0;
  logic        i_srst = 1'b1;
  logic        go = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  lanes = 4'hf;
  logic        ready;
  logic        done;
  logic        busy;
  logic [31:0] rdata;
  logic [32:0] note;
  logic [31:0] mem [16];
  logic [32:0] notes [$];
  logic [3:0]  legal [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
  int          fails = 0;
  int          checks = 0;
  mmw_if u_mmw_if (.i_clock(i_clock));
  mmw_slave u_mmw_slave (.i_clock(i_clock), .i_srst(i_srst), .bus(u_mmw_if), .o_busy(busy));
  mmw_fabric u_mmw_fabric (.i_clock(i_clock), .i_srst(i_srst), .bus(u_mmw_if), .i_go(go), .i_write(write),
    .i_addr(addr), .i_wdata(wdata), .i_lanes(lanes), .o_ready(ready), .o_done(done), .o_rdata(rdata));
  mmw_checker #(.WAIT_C(mmw_pkg::WAIT_CYC_DEF)) u_mmw_checker (.i_clock(i_clock), .i_srst(i_srst),
    .i_rd(u_mmw_if.rd), .i_wr(u_mmw_if.wr), .i_addr(u_mmw_if.addr), .i_wdata(u_mmw_if.wdata),
    .i_rdata(u_mmw_if.rdata), .i_lane_en(u_mmw_if.lane_en), .i_first(u_mmw_if.first),
    .i_stall(u_mmw_if.stall));
  // 100 MHz clock
  initial forever #5 i_clock = ~i_clock;
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one command; model updated up front since commands never overlap
  task automatic op(logic w, logic [3:0] a, logic [31:0] d, logic [3:0] l);
    int n;
    n = 0;
    notes.push_back({!w, mem[a]});
    if (w) for (int g = 0; g < 4; g++) if (l[g]) mem[a][8*g+:8] = d[8*g+:8];
    @(posedge i_clock);
    go <= 1'b1;
    write <= w;
    addr <= a;
    wdata <= d;
    lanes <= l;
    @(posedge i_clock);
    go <= 1'b0;
    #1;
    check("link", {u_mmw_if.first, u_mmw_if.lane_en, u_mmw_if.addr}, {1'b1, l, a});
    while (done !== 1'b1 && n < 20) begin
      @(posedge i_clock);
      #1;
      n++;
      if (n == 1) check("busy", busy, 1);
    end
    check("latency", n, mmw_pkg::WAIT_CYC_DEF + 2);
  endtask
  // oldest note against each answer
  always @(posedge i_clock) begin
    if (done === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note[32]) check("rdata", rdata, note[31:0]);
    end
  end
  initial begin
    void'($urandom(32'hdde6_3de3));
    repeat (16) @(posedge i_clock);
    i_srst <= 1'b0;
    @(negedge i_clock);
    check("idle stall", u_mmw_if.stall, 1);
    check("ready", ready, 1);
    // fill every word, then read each back
    for (int a = 0; a < 16; a++) op(1, a[3:0], $urandom(), 4'hf);
    for (int a = 0; a < 16; a++) op(0, a[3:0], 0, 4'hf);
    // random traffic over every legal lane group
    for (int i = 0; i < 60; i++) op(1'($urandom_range(1)), 4'($urandom_range(15)), $urandom(), legal[i % 7]);
    // an illegal lane group starts nothing
    @(posedge i_clock);
    go <= 1'b1;
    lanes <= 4'h5;
    @(posedge i_clock);
    go <= 1'b0;
    repeat (3) @(posedge i_clock);
    #1;
    check("busy", busy, 0);
    conclude();
  end
  // hang guard, well past the expected run
  initial begin
    repeat (5000) @(posedge i_clock);
    fails++;
    conclude();
  end
endmodule
